// ---- hfs_defs.svh ----
// Hotswap fault sequencer constants: timing, limit codes, counter width.
// Assumes a single 250 MHz clock; included by the package and all modules but hfs_sync and hfs_timer.
//
// Contract
// - Internal supply invalid holds everything reset, off; the code keeps the thermal latch through it.
// - Gate voltage before init forces fast clamp.
// - Undervoltage anywhere turns off, resets sequencing.
// - Undervoltage recovery restarts from first stage.
// - Power-on-reset delay 4.5ms before enabling.
// - Undervoltage during delay restarts delay from zero.
// - Full delay first, then 230mA source.
// - Inrush limit 230mA until load exceeds 1V.
// - Inrush breaker trips unless load 3/4 in 40ms.
// - Drain not below quarter in 75ms: short, retry 9s.
// - Drain within 1V of supply: pulsed limit; the code pulses only in the inrush and overcurrent stages.
// - Pulsed short limit holds about 230mA.
// - Inrush done: gate fully on, power good low.
// - Current above 2A reverts to 1.2A source.
// - Overcurrent 75ms timer, then off, 9s retry.
// - Overcurrent cleared early resets its timer.
// - Breaker limits within 10us, settles 100us.
// - Auto-retry repeats forever unless thermally held.
// - Overtemperature shuts down; restart after cool below 100C.
`ifndef HFS_DEFS_SVH
`define HFS_DEFS_SVH

`define HFS_CLK_MHZ 32'hFA
`define HFS_POR_US 4500
`define HFS_INRUSH_US 40000
`define HFS_SC_US 75000
`define HFS_OC_US 75000
`define HFS_RETRY_US 9000000
`define HFS_REACT_NS 10000
`define HFS_SETTLE_NS 100000
`define HFS_PWM_PERIOD_NS 10000
`define HFS_PWM_ON_NS 2000
`define HFS_US_CYCLES(us) ((us) * `HFS_CLK_MHZ)
`define HFS_NS_CYCLES(ns) (((ns) * `HFS_CLK_MHZ) / 1000)
`define HFS_CNT_W 32

// Limit codes on the servo port
`define HFS_LIM_OFF 3'h0
`define HFS_LIM_LOW 3'h1
`define HFS_LIM_HIGH 3'h2
`define HFS_LIM_PWM 3'h3
`define HFS_LIM_FULL 3'h4

`endif

// ---- hfs_far.sv ----
// Supply rail, load capacitor and downstream converter around the sequencer.
// Assumes the limit codes of hfs_defs.svh; shorted pins the load at zero.
`timescale 1ns/100ps
`include "hfs_defs.svh"
module hfs_far
(
   input wire logic clk,
   input wire logic shorted,
   input wire logic [2:0] limit_sel,
   input wire logic power_good_n_o,
   input wire logic power_good_n_oe,
   output logic load_above_1v,
   output logic load_above_3q,
   output logic vds_below_quarter,
   output logic drain_near_supply,
   output logic pg_pin
);
   int load_r = 0;
   // Charge rate follows the limit code; off or shorted drains the load
   always_ff @(posedge clk)
   begin
      if (shorted || limit_sel == `HFS_LIM_OFF)
         load_r <= 0;
      else if (limit_sel == `HFS_LIM_LOW || limit_sel == `HFS_LIM_PWM)
         load_r <= load_r + 1;
      else if (load_r < 100)
         load_r <= load_r + 4;
   end
   assign load_above_1v = load_r >= 10;
   assign load_above_3q = load_r >= 75;
   assign vds_below_quarter = load_r >= 75;
   assign drain_near_supply = shorted;
   // Pull-up on the converter side of the open drain flag
   assign pg_pin = power_good_n_oe ? power_good_n_o : 1'b1;
endmodule

// ---- hfs_monitor.sv ----
// Checker of the sequencer outputs against the comparator inputs.
// Assumes binding onto hotswap_fault_sequencer; POR_CYCLES follows the instance.
`timescale 1ns/100ps
`include "hfs_defs.svh"
module hfs_chk
#(
   parameter hfs_pkg::hfs_cnt_t POR_CYCLES = 50
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic supply_valid,
   input wire logic undervoltage_lockout,
   input wire logic current_above_2a,
   input wire logic gate_enable,
   input wire logic gate_clamp,
   input wire logic [2:0] limit_sel,
   input wire logic power_good_n_o,
   input wire logic power_good_n_oe,
   input wire logic fault_short,
   input wire logic fault_overcurrent,
   input wire logic thermal_hold
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   int ok_cnt_r;
   // Cycles since the input last became good
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         ok_cnt_r <= 0;
      else if (!supply_valid || undervoltage_lockout)
         ok_cnt_r <= 0;
      else
         ok_cnt_r <= ok_cnt_r + 1;
   end
   supply_hold_a: assert property (!supply_valid [*6] |-> !gate_enable && !power_good_n_oe)
      else $error("gate or flag active without supply");
   clamp_off_a: assert property (gate_clamp |-> !gate_enable)
      else $error("gate driven while clamped");
   lockout_off_a: assert property (undervoltage_lockout [*6] |->
      limit_sel == `HFS_LIM_OFF && !power_good_n_oe)
      else $error("gate or flag active in lockout");
   por_delay_a: assert property ($rose(gate_enable) |-> ok_cnt_r > POR_CYCLES)
      else $error("gate on before full delay");
   good_full_a: assert property ($rose(power_good_n_oe) |->
      limit_sel == `HFS_LIM_FULL && power_good_n_o == 1'b0)
      else $error("flag low without full gate");
   oc_limit_a: assert property (current_above_2a [*6] |->
      limit_sel != `HFS_LIM_FULL && !power_good_n_oe)
      else $error("full gate kept during overcurrent");
   oc_off_a: assert property ($rose(fault_overcurrent) |-> ##1 !gate_enable [*3])
      else $error("gate on after overcurrent fault");
   short_off_a: assert property ($rose(fault_short) |-> ##1 !gate_enable [*3])
      else $error("gate on after short fault");
   thermal_off_a: assert property (thermal_hold [*6] |-> !gate_enable)
      else $error("gate on while thermally held");
endmodule
bind hotswap_fault_sequencer hfs_chk #(.POR_CYCLES(POR_CYCLES)) hfs_chk_i (.clk(clk),
   .rst(rst), .supply_valid(supply_valid), .undervoltage_lockout(undervoltage_lockout),
   .current_above_2a(current_above_2a), .gate_enable(gate_enable), .gate_clamp(gate_clamp),
   .limit_sel(limit_sel), .power_good_n_o(power_good_n_o), .power_good_n_oe(power_good_n_oe),
   .fault_short(fault_short), .fault_overcurrent(fault_overcurrent),
   .thermal_hold(thermal_hold));

// ---- hfs_pkg.sv ----
// Hotswap fault sequencer types.
// Assumes hfs_defs.svh is on the include path.
`include "hfs_defs.svh"
package hfs_pkg;
   typedef enum logic [2:0] {
      HFS_ST_LOCKOUT,
      HFS_ST_POR,
      HFS_ST_INRUSH,
      HFS_ST_ON,
      HFS_ST_OVERCUR,
      HFS_ST_RETRY
   } hfs_state_t;
   typedef logic [`HFS_CNT_W-1:0] hfs_cnt_t;
endpackage

// ---- hfs_sync.sv ----
// Two-flop synchroniser for asynchronous comparator inputs.
// Assumes clk is the block clock and rst clears to inactive.
`timescale 1ns/100ps
module hfs_sync
(
   input wire logic clk,
   input wire logic rst,
   input wire logic d,
   output logic q
);
   logic meta_r;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_r <= 1'b0;
         q <= 1'b0;
      end
      else
      begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// ---- hfs_timer.sv ----
// Up-counter with clear, run and a terminal compare.
// Assumes run and clr come from logic on the same clock.
`timescale 1ns/100ps
module hfs_timer
(
   input wire logic clk,
   input wire logic rst,
   input wire logic clr,
   input wire logic run,
   input hfs_pkg::hfs_cnt_t limit,
   output logic done
);
   hfs_pkg::hfs_cnt_t cnt_r;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         cnt_r <= '0;
      else if (clr)
         cnt_r <= '0;
      else if (run && !done)
         cnt_r <= cnt_r + 1'b1;
   end

   assign done = (cnt_r >= limit);
endmodule

// ---- hotswap_fault_sequencer.sv ----
// Digital sequencer of an inrush limiter and circuit breaker.
// Assumes analog comparators arrive asynchronously; the servo reads limit_sel.
`timescale 1ns/100ps
`include "hfs_defs.svh"
module hotswap_fault_sequencer
#(
   parameter hfs_pkg::hfs_cnt_t POR_CYCLES = `HFS_US_CYCLES(`HFS_POR_US),
   parameter hfs_pkg::hfs_cnt_t INRUSH_CYCLES = `HFS_US_CYCLES(`HFS_INRUSH_US),
   parameter hfs_pkg::hfs_cnt_t SC_CYCLES = `HFS_US_CYCLES(`HFS_SC_US),
   parameter hfs_pkg::hfs_cnt_t OC_CYCLES = `HFS_US_CYCLES(`HFS_OC_US),
   parameter hfs_pkg::hfs_cnt_t RETRY_CYCLES = `HFS_US_CYCLES(`HFS_RETRY_US)
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic supply_valid,
   input wire logic gate_sense,
   input wire logic undervoltage_lockout,
   input wire logic load_above_1v,
   input wire logic load_above_3q,
   input wire logic vds_below_quarter,
   input wire logic drain_near_supply,
   input wire logic current_above_2a,
   input wire logic temp_hot,
   input wire logic temp_cool,
   output logic gate_enable,
   output logic gate_clamp,
   output logic [2:0] limit_sel,
   output logic power_good_n_o,
   output logic power_good_n_oe,
   output logic fault_short,
   output logic fault_overcurrent,
   output logic thermal_hold
);
   // Servo reaction, settle and pulsed-limit timings, in cycles
   localparam hfs_pkg::hfs_cnt_t REACT_CYCLES = `HFS_NS_CYCLES(`HFS_REACT_NS);
   localparam hfs_pkg::hfs_cnt_t SETTLE_CYCLES = `HFS_NS_CYCLES(`HFS_SETTLE_NS);
   localparam hfs_pkg::hfs_cnt_t PWM_PERIOD = `HFS_NS_CYCLES(`HFS_PWM_PERIOD_NS);
   localparam hfs_pkg::hfs_cnt_t PWM_ON = `HFS_NS_CYCLES(`HFS_PWM_ON_NS);

   hfs_pkg::hfs_state_t state_r;
   hfs_pkg::hfs_state_t state_nxt;
   logic sup_ok;
   logic gate_s;
   logic uv_s;
   logic l1v_s;
   logic l3q_s;
   logic vdsq_s;
   logic near_s;
   logic oc_s;
   logic hot_s;
   logic cool_s;
   logic init_r;
   logic thermal_r;
   logic short_r;
   logic ocflag_r;
   logic pwm_mode_r;
   logic settling_r;
   logic [`HFS_CNT_W-1:0] pwm_cnt_r;
   logic [`HFS_CNT_W-1:0] settle_cnt_r;
   logic por_done;
   logic inr_done;
   logic sc_done;
   logic oc_done;
   logic rt_done;
   logic seq_reset;
   logic hold_off;
   logic por_clr;
   logic inr_clr;
   logic sc_clr;
   logic oc_clr;
   logic rt_clr;

   // Internal supply gate: everything below except the thermal latch restarts when it drops
   hfs_sync u_sync_sup
   (
      .clk(clk),
      .rst(rst),
      .d(supply_valid),
      .q(sup_ok)
   );
   hfs_sync u_sync_gate (.clk(clk), .rst(rst), .d(gate_sense), .q(gate_s));
   hfs_sync u_sync_uv (.clk(clk), .rst(rst), .d(undervoltage_lockout), .q(uv_s));
   hfs_sync u_sync_l1v (.clk(clk), .rst(rst), .d(load_above_1v), .q(l1v_s));
   hfs_sync u_sync_l3q (.clk(clk), .rst(rst), .d(load_above_3q), .q(l3q_s));
   hfs_sync u_sync_vds (.clk(clk), .rst(rst), .d(vds_below_quarter), .q(vdsq_s));
   hfs_sync u_sync_near (.clk(clk), .rst(rst), .d(drain_near_supply), .q(near_s));
   hfs_sync u_sync_oc (.clk(clk), .rst(rst), .d(current_above_2a), .q(oc_s));
   hfs_sync u_sync_hot (.clk(clk), .rst(rst), .d(temp_hot), .q(hot_s));
   hfs_sync u_sync_cool (.clk(clk), .rst(rst), .d(temp_cool), .q(cool_s));

   // Undervoltage or a lost internal supply clears all sequencing
   assign seq_reset = !sup_ok || uv_s;

   // Gate voltage before initialisation keeps the servo off
   assign hold_off = seq_reset || (gate_s && !init_r);

   function automatic logic in_state(input hfs_pkg::hfs_state_t s,
                                     input hfs_pkg::hfs_state_t want);
      in_state = (s == want);
   endfunction

   // Initialisation completes one cycle after the supply is seen valid
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         init_r <= 1'b0;
      else
         init_r <= sup_ok;
   end

   // Thermal latch with hysteresis: set wins over release
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         thermal_r <= 1'b0;
      else if (hot_s)
         thermal_r <= 1'b1;
      else if (cool_s)
         thermal_r <= 1'b0;
   end

   // Each timer restarts whenever its stage is left or the sequence resets
   assign por_clr = seq_reset || !in_state(state_r, hfs_pkg::HFS_ST_POR);
   assign inr_clr = seq_reset || !in_state(state_r, hfs_pkg::HFS_ST_INRUSH);
   assign sc_clr = seq_reset || !in_state(state_r, hfs_pkg::HFS_ST_INRUSH);
   assign oc_clr = seq_reset || !in_state(state_r, hfs_pkg::HFS_ST_OVERCUR) || !oc_s;
   assign rt_clr = seq_reset || !in_state(state_r, hfs_pkg::HFS_ST_RETRY);

   hfs_timer u_por
   (
      .clk(clk),
      .rst(rst),
      .clr(por_clr),
      .run(1'b1),
      .limit(POR_CYCLES),
      .done(por_done)
   );

   hfs_timer u_inr
   (
      .clk(clk),
      .rst(rst),
      .clr(inr_clr),
      .run(1'b1),
      .limit(INRUSH_CYCLES),
      .done(inr_done)
   );

   hfs_timer u_sc
   (
      .clk(clk),
      .rst(rst),
      .clr(sc_clr),
      .run(1'b1),
      .limit(SC_CYCLES),
      .done(sc_done)
   );

   hfs_timer u_oc
   (
      .clk(clk),
      .rst(rst),
      .clr(oc_clr),
      .run(1'b1),
      .limit(OC_CYCLES),
      .done(oc_done)
   );

   hfs_timer u_rt
   (
      .clk(clk),
      .rst(rst),
      .clr(rt_clr),
      .run(1'b1),
      .limit(RETRY_CYCLES),
      .done(rt_done)
   );

   // Stage sequencing; a thermal hold overrides every stage
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         hfs_pkg::HFS_ST_LOCKOUT:
         begin
            if (init_r && !thermal_r)
               state_nxt = hfs_pkg::HFS_ST_POR;
         end
         hfs_pkg::HFS_ST_POR:
         begin
            if (por_done)
               state_nxt = hfs_pkg::HFS_ST_INRUSH;
         end
         hfs_pkg::HFS_ST_INRUSH:
         begin
            if (sc_done && !vdsq_s)
               state_nxt = hfs_pkg::HFS_ST_RETRY;
            else if (inr_done && !l3q_s)
               state_nxt = hfs_pkg::HFS_ST_RETRY;
            else if (l3q_s && vdsq_s)
               state_nxt = hfs_pkg::HFS_ST_ON;
         end
         hfs_pkg::HFS_ST_ON:
         begin
            if (oc_s)
               state_nxt = hfs_pkg::HFS_ST_OVERCUR;
         end
         hfs_pkg::HFS_ST_OVERCUR:
         begin
            if (oc_done)
               state_nxt = hfs_pkg::HFS_ST_RETRY;
            else if (!oc_s && !settling_r)
               state_nxt = hfs_pkg::HFS_ST_ON;
         end
         hfs_pkg::HFS_ST_RETRY:
         begin
            if (rt_done && !thermal_r)
               state_nxt = hfs_pkg::HFS_ST_LOCKOUT;
         end
      endcase
      if (thermal_r)
         state_nxt = hfs_pkg::HFS_ST_LOCKOUT;
   end

   // Undervoltage pulls the stage back to lockout from anywhere
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         state_r <= hfs_pkg::HFS_ST_LOCKOUT;
      else if (seq_reset)
         state_r <= hfs_pkg::HFS_ST_LOCKOUT;
      else
         state_r <= state_nxt;
   end

   // Fault flags stand until the next start-up attempt
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         short_r <= 1'b0;
         ocflag_r <= 1'b0;
      end
      else if (seq_reset)
      begin
         short_r <= 1'b0;
         ocflag_r <= 1'b0;
      end
      else if (in_state(state_r, hfs_pkg::HFS_ST_INRUSH)
               && in_state(state_nxt, hfs_pkg::HFS_ST_RETRY))
         short_r <= 1'b1;
      else if (in_state(state_r, hfs_pkg::HFS_ST_OVERCUR)
               && in_state(state_nxt, hfs_pkg::HFS_ST_RETRY))
         ocflag_r <= 1'b1;
      else if (in_state(state_r, hfs_pkg::HFS_ST_POR))
      begin
         short_r <= 1'b0;
         ocflag_r <= 1'b0;
      end
   end

   // Pulsed limit engages while the drain stays near supply in the inrush or overcurrent stage
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         pwm_mode_r <= 1'b0;
      else
         pwm_mode_r <= near_s && (in_state(state_r, hfs_pkg::HFS_ST_INRUSH)
                       || in_state(state_r, hfs_pkg::HFS_ST_OVERCUR));
   end

   // Phase counter of the pulsed limit, idle at zero outside it
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         pwm_cnt_r <= '0;
      else if (!pwm_mode_r || pwm_cnt_r >= PWM_PERIOD - 1'b1)
         pwm_cnt_r <= '0;
      else
         pwm_cnt_r <= pwm_cnt_r + 1'b1;
   end

   // Settle window after a breaker trip keeps the limit from chattering
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         settle_cnt_r <= '0;
         settling_r <= 1'b0;
      end
      else if (!in_state(state_r, hfs_pkg::HFS_ST_OVERCUR))
      begin
         settle_cnt_r <= '0;
         settling_r <= 1'b1;
      end
      else if (settle_cnt_r < SETTLE_CYCLES)
      begin
         settle_cnt_r <= settle_cnt_r + 1'b1;
         settling_r <= 1'b1;
      end
      else
         settling_r <= 1'b0;
   end

   // Servo limit select; breaker reacts well inside the 10us budget
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         limit_sel <= `HFS_LIM_OFF;
      else if (hold_off)
         limit_sel <= `HFS_LIM_OFF;
      else if (pwm_mode_r)
         limit_sel <= (pwm_cnt_r < PWM_ON) ? `HFS_LIM_PWM : `HFS_LIM_OFF;
      else
         unique case (state_nxt)
            hfs_pkg::HFS_ST_INRUSH:
               limit_sel <= l1v_s ? `HFS_LIM_HIGH : `HFS_LIM_LOW;
            hfs_pkg::HFS_ST_ON:
               limit_sel <= `HFS_LIM_FULL;
            hfs_pkg::HFS_ST_OVERCUR:
               limit_sel <= `HFS_LIM_HIGH;
            default:
               limit_sel <= `HFS_LIM_OFF;
         endcase
   end

   // Clamp stands from reset until the sequencer is initialised
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         gate_clamp <= 1'b1;
      else
         gate_clamp <= !init_r || seq_reset;
   end

   // Flag pulls low only in the full-on stage, otherwise left open
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         power_good_n_oe <= 1'b0;
      else
         power_good_n_oe <= !seq_reset && in_state(state_nxt, hfs_pkg::HFS_ST_ON);
   end

   assign power_good_n_o = 1'b0;
   assign gate_enable = (limit_sel != `HFS_LIM_OFF);
   assign fault_short = short_r;
   assign fault_overcurrent = ocflag_r;
   assign thermal_hold = thermal_r;
endmodule

// ---- testbench.sv ----
// Self-checking bench of the sequencer with its far-side model.
// Assumes small timer parameters so the whole run stays short.
`timescale 1ns/100ps
`include "hfs_defs.svh"
module testbench;
   typedef struct {
      logic uv, ovc;
      int wt;
      logic [2:0] lim;
      logic pg, fo;
   } hfs_row_t;
   hfs_row_t rows [8] = '{'{0, 0, 60, `HFS_LIM_FULL, 0, 0}, '{0, 1, 20, `HFS_LIM_HIGH, 1, 0},
      '{0, 0, 25200, `HFS_LIM_FULL, 0, 0}, '{0, 1, 10, `HFS_LIM_HIGH, 1, 0},
      '{0, 1, 120, `HFS_LIM_OFF, 1, 1}, '{0, 0, 250, `HFS_LIM_OFF, 1, 1},
      '{0, 0, 300, `HFS_LIM_FULL, 0, 0}, '{1, 0, 10, `HFS_LIM_OFF, 1, 0}};
   logic clk, rst, supply_valid, gate_sense, uv, ovc, hot, cool, sh;
   logic l1v, l3q, vdsq, dns, gate_enable, gate_clamp, pg_o, pg_oe, f_sc, f_oc, th, pg_pin;
   logic [2:0] limit_sel;
   int n_fail = 0;
   int total_checks = 0;
   int n, pw;
   hotswap_fault_sequencer #(.POR_CYCLES(50), .INRUSH_CYCLES(800), .SC_CYCLES(900),
      .OC_CYCLES(100), .RETRY_CYCLES(400)) hotswap_fault_sequencer_i (.clk(clk), .rst(rst),
      .supply_valid(supply_valid), .gate_sense(gate_sense), .undervoltage_lockout(uv),
      .load_above_1v(l1v), .load_above_3q(l3q), .vds_below_quarter(vdsq),
      .drain_near_supply(dns), .current_above_2a(ovc), .temp_hot(hot), .temp_cool(cool),
      .gate_enable(gate_enable), .gate_clamp(gate_clamp), .limit_sel(limit_sel),
      .power_good_n_o(pg_o), .power_good_n_oe(pg_oe), .fault_short(f_sc),
      .fault_overcurrent(f_oc), .thermal_hold(th));
   hfs_far hfs_far_i (.clk(clk), .shorted(sh), .limit_sel(limit_sel), .power_good_n_o(pg_o),
      .power_good_n_oe(pg_oe), .load_above_1v(l1v), .load_above_3q(l3q),
      .vds_below_quarter(vdsq), .drain_near_supply(dns), .pg_pin(pg_pin));
   initial
   begin
      clk = 0;
      forever #2 clk = ~clk;
   end
   task automatic tick(int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic cmp(string nm, logic [2:0] exp, logic [2:0] got);
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   task automatic tally_and_finish;
      if (n_fail == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (40000) @(posedge clk);
      n_fail++;
      tally_and_finish;
   end
   initial
   begin
      {rst, gate_sense, uv, cool} = 4'hF;
      {supply_valid, ovc, hot, sh} = 4'h0;
      tick(6);
      rst = 0;
      tick(20);
      cmp("clamp", 1, gate_clamp);
      cmp("gate", `HFS_LIM_OFF, limit_sel);
      cmp("flag", 1, pg_pin);
      {gate_sense, supply_valid, uv} = 3'h2;
      tick(30);
      uv = 1;
      tick(5);
      uv = 0;
      for (n = 0; gate_enable !== 1'b1 && n < 200; n++)
         tick(1);
      cmp("por_len", 1, n >= 50 && n < 80);
      cmp("first_lim", `HFS_LIM_LOW, limit_sel);
      cmp("clamp_rel", 0, gate_clamp);
      for (n = 0; limit_sel === `HFS_LIM_LOW && n < 100; n++)
         tick(1);
      cmp("raised_lim", `HFS_LIM_HIGH, limit_sel);
      foreach (rows[i])
      begin
         uv = rows[i].uv;
         ovc = rows[i].ovc;
         tick(rows[i].wt);
         cmp("lim", rows[i].lim, limit_sel);
         cmp("flag", rows[i].pg, pg_pin);
         cmp("oc_fault", rows[i].fo, f_oc);
      end
      {sh, uv} = 2'h2;
      tick(60);
      pw = 0;
      repeat (700)
      begin
         tick(1);
         if (limit_sel === `HFS_LIM_PWM)
            pw++;
         else
            cmp("short_lim", `HFS_LIM_OFF, limit_sel);
      end
      cmp("pulsed", 1, pw > 0 && pw < 700);
      tick(150);
      cmp("sc_fault", 1, f_sc);
      cmp("sc_lim", `HFS_LIM_OFF, limit_sel);
      {sh, hot, cool} = 3'h2;
      tick(10);
      cmp("hold", 1, th);
      hot = 0;
      tick(600);
      cmp("held_lim", `HFS_LIM_OFF, limit_sel);
      cmp("held_gate", 0, gate_enable);
      cool = 1;
      tick(150);
      cmp("cool_lim", `HFS_LIM_FULL, limit_sel);
      cmp("cool_hold", 0, th);
      rst = 1;
      tick(6);
      cmp("rst_lim", `HFS_LIM_OFF, limit_sel);
      cmp("rst_clamp", 1, gate_clamp);
      cmp("rst_flag", 1, pg_pin);
      rst = 0;
      tick(150);
      cmp("rerun_lim", `HFS_LIM_FULL, limit_sel);
      tally_and_finish;
   end
endmodule
